// [src/sls_pkg.sv]
// Purpose: Shared constants and types for the stepper limit seek block
// Assumes: 50 MHz ref_clk, APB register access, 32-bit data
// Notes: All offsets are byte addresses of aligned words
package sls_pkg;
  // Clock and step source rates in Hz
  localparam int CLK_HZ = 50_000_000;
  localparam int INT_SRC_HZ = 25_500;
  localparam int ONB_SRC_HZ = 800_000;
  localparam int NUM_AXES = 3;
  // Divisor limits for the constant-speed seek
  localparam logic [7:0] DIV_MIN = 8'h14;
  localparam logic [7:0] DIV_MAX = 8'hFF;
  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STEPS = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_CLKCFG = 8'h0C;
  localparam logic [7:0] OFS_RAMP = 8'h10;
  localparam logic [7:0] OFS_STAT0 = 8'h14;
  localparam logic [7:0] OFS_STAT1 = 8'h18;
  localparam logic [7:0] OFS_STAT2 = 8'h1C;
  // Field positions
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_AXIS_LSB = 8;
  localparam int CMD_DIV_LSB = 16;
  localparam int STEPS_SIGN_BIT = 24;
  localparam int CFG_SRC_LSB = 0;
  localparam int CFG_X_LSB = 8;
  localparam int FIN_INNER_BIT = 3;
  localparam int FIN_OUTER_BIT = 4;
  localparam int FIN_MOTOR_OFF_BIT = 5;
  localparam int STAT_BUSY_BIT = 8;
  // Command and result codes
  localparam logic [7:0] CMD_OUTER = 8'h05;
  localparam logic [7:0] CMD_INNER = 8'h06;
  localparam logic [7:0] CMD_MAX = 8'h0F;
  localparam logic [3:0] RES_OK = 4'h0;
  localparam logic [3:0] RES_BUSY = 4'h1;
  localparam logic [3:0] RES_BADCMD = 4'h5;
  localparam logic [3:0] RES_POWER = 4'h6;
  localparam logic [3:0] RES_BADAXIS = 4'hA;
  localparam logic [3:0] RES_BADDIV = 4'hB;
  // Clock source selections
  localparam logic [1:0] SRC_INT = 2'h0;
  localparam logic [1:0] SRC_ONB = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  // Reset values
  localparam logic [31:0] RAMP_RESET = 32'h0004_1478;
  localparam logic [31:0] CLKCFG_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] div;
    logic [3:0] axis;
    logic [7:0] code;
  } sls_cmd_t;

  typedef struct packed {
    logic [7:0] len;
    logic [7:0] top;
    logic [7:0] start;
  } sls_ramp_t;

  typedef enum logic [1:0] {ST_IDLE, ST_CONST, ST_ACCEL, ST_DECEL} sls_state_t;
endpackage : sls_pkg

// [src/sls_tick_gen.sv]
// Purpose: Fractional rate tick from the system clock
// Assumes: INC below MOD, both in Hz
// Notes: Average rate is exact; jitter is one ref_clk period
`timescale 1ns/1ns
`default_nettype none
module sls_tick_gen #(
  parameter int INC = 25_500,
  parameter int MOD = 50_000_000
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  output logic tick
);
  localparam int ACC_W = $clog2(2 * MOD);
  localparam logic [ACC_W-1:0] INC_V = ACC_W'(INC);
  localparam logic [ACC_W-1:0] MOD_V = ACC_W'(MOD);
  logic [ACC_W-1:0] accFf;
  logic [ACC_W-1:0] nxt_acc;

  if (INC <= 0 || INC >= MOD) begin : g_chk
    $error("sls_tick_gen: INC must lie between 0 and MOD");
  end

  assign nxt_acc = accFf + INC_V;

  // Phase accumulator, wraps at MOD
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      accFf <= '0;
      tick <= 1'b0;
    end else if (nxt_acc >= MOD_V) begin
      accFf <= nxt_acc - MOD_V;
      tick <= 1'b1;
    end else begin
      accFf <= nxt_acc;
      tick <= 1'b0;
    end
  end
endmodule : sls_tick_gen
`default_nettype wire

// [src/sls_step_timer.sv]
// Purpose: Counts source ticks and emits one step per divisor periods
// Assumes: divisor of at least one
// Notes: Counter clears whenever run is low
`timescale 1ns/1ns
`default_nettype none
module sls_step_timer #(
  parameter int DIV_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic srcTick,
  input wire logic [DIV_W-1:0] divisor,
  output logic stepPulse
);
  logic [DIV_W-1:0] cntFf;

  if (DIV_W < 2) begin : g_chk
    $error("sls_step_timer: DIV_W too small");
  end

  // Reload after each pulse; divisor read live
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !run) begin
      cntFf <= '0;
      stepPulse <= 1'b0;
    end else if (srcTick && (cntFf + 1'b1 >= divisor)) begin
      cntFf <= '0;
      stepPulse <= 1'b1;
    end else begin
      cntFf <= srcTick ? cntFf + 1'b1 : cntFf;
      stepPulse <= 1'b0;
    end
  end
endmodule : sls_step_timer
`default_nettype wire

// [src/sls_seek_top.sv]
// Purpose: Three-axis stepper seek to outer or inner limit switches
// Assumes: APB master, synchronous switch and ext clock inputs
// Notes: Rules of the block follow
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module sls_seek_top
  import sls_pkg::*;
#(
  parameter int N_AXES = NUM_AXES,
  parameter int DIV_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extClkIn,
  input wire logic motor_power_sense,
  input wire logic [N_AXES-1:0] cw_outer_limit,
  input wire logic [N_AXES-1:0] ccw_outer_limit,
  input wire logic [N_AXES-1:0] cw_inner_limit,
  input wire logic [N_AXES-1:0] ccw_inner_limit,
  output logic [N_AXES-1:0] stepPulse,
  output logic [N_AXES-1:0] stepDir
);
  // Elaboration checks
  if (N_AXES != NUM_AXES) begin : g_chk_axes
    $error("sls_seek_top: axis decode serves exactly three axes");
  end
  if (DIV_W != 8) begin : g_chk_div
    $error("sls_seek_top: divisor fields are eight bits");
  end
  // Register state
  logic [31:0] stepsFf;
  logic [3:0] resultFf;
  logic [1:0] srcSelFf;
  logic [7:0] dividerXFf;
  sls_ramp_t rampFf;
  // Bus handshake
  logic accFirst;
  logic accDone;
  logic wrDone;
  logic cmdWrite;
  sls_cmd_t cmdReq;
  // Command checks
  logic [3:0] nxt_result;
  logic [N_AXES-1:0] startVec;
  logic dirReq;
  // Source ticks
  logic intTick;
  logic onbTick;
  logic preTick;
  logic extPrevFf;
  logic [7:0] preCntFf;
  logic srcTickFf;
  // Per-axis state
  sls_state_t stateFf [N_AXES];
  logic [7:0] curDivFf [N_AXES];
  logic [7:0] rampCntFf [N_AXES];
  logic [2:0] lastCodeFf [N_AXES];
  logic [N_AXES-1:0] finInnerFf;
  logic [N_AXES-1:0] finOuterFf;
  logic [N_AXES-1:0] busy;
  logic [N_AXES-1:0] stepInt;
  // Access phase: first cycle prepares, second completes
  assign accFirst = psel & penable & ~pready;
  assign accDone = psel & penable & pready;
  assign wrDone = accDone & pwrite;
  assign cmdWrite = wrDone && (paddr == OFS_CMD);
  assign cmdReq.code = pwdata[CMD_CODE_LSB +: 8];
  assign cmdReq.axis = pwdata[CMD_AXIS_LSB +: 4];
  assign cmdReq.div = pwdata[CMD_DIV_LSB +: 8];
  // Sign of the stored count; zero counts as clockwise
  assign dirReq = ~stepsFf[STEPS_SIGN_BIT];
  // Command screening, first failing check reports
  always_comb begin
    nxt_result = RES_OK;
    startVec = '0;
    if (cmdReq.code > CMD_MAX) begin
      nxt_result = RES_BADCMD;
    end else if (cmdReq.axis >= 4'(N_AXES)) begin
      nxt_result = RES_BADAXIS;
    end else if (cmdReq.code == CMD_OUTER &&
                 (cmdReq.div < DIV_MIN || cmdReq.div > DIV_MAX)) begin
      nxt_result = RES_BADDIV;
    end else if (!motor_power_sense) begin
      nxt_result = RES_POWER;
    end else if (busy[cmdReq.axis[1:0]]) begin
      nxt_result = RES_BUSY;
    end else if (cmdReq.code == CMD_OUTER || cmdReq.code == CMD_INNER) begin
      startVec[cmdReq.axis[1:0]] = cmdWrite;
    end
  end

  // Bus handshake flops
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= accFirst;
    end
  end

  // Read data and error, latched in the first access cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (accFirst) begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      case (paddr)
        OFS_CMD: prdata <= 32'h0000_0000;
        OFS_STEPS: prdata <= stepsFf;
        OFS_RESULT: prdata <= {28'h000_0000, resultFf};
        OFS_CLKCFG: prdata <= {16'h0000, dividerXFf, 6'h00, srcSelFf};
        OFS_RAMP: prdata <= {8'h00, rampFf};
        OFS_STAT0: prdata <= statWord(0);
        OFS_STAT1: prdata <= statWord(1);
        OFS_STAT2: prdata <= statWord(2);
        default: pslverr <= 1'b1; // Unmapped address
      endcase
    end else begin
      pslverr <= 1'b0; // Error stands for the answer cycle only
    end
  end

  // Finish status word of one axis
  function automatic logic [31:0] statWord(input int a);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[2:0] = lastCodeFf[a];
    w[FIN_INNER_BIT] = finInnerFf[a];
    w[FIN_OUTER_BIT] = finOuterFf[a];
    w[FIN_MOTOR_OFF_BIT] = ~motor_power_sense;
    w[STAT_BUSY_BIT] = busy[a];
    return w;
  endfunction : statWord

  // Stored step count
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stepsFf <= 32'h0000_0000;
    end else if (wrDone && paddr == OFS_STEPS) begin
      stepsFf <= pwdata;
    end
  end

  // Clock source and divider ratio, live during motion
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      srcSelFf <= CLKCFG_RESET[CFG_SRC_LSB +: 2];
      dividerXFf <= CLKCFG_RESET[CFG_X_LSB +: 8];
    end else if (wrDone && paddr == OFS_CLKCFG) begin
      srcSelFf <= pwdata[CFG_SRC_LSB +: 2];
      dividerXFf <= pwdata[CFG_X_LSB +: 8];
    end
  end

  // Stored ramp settings; only a ramp write changes them
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rampFf <= RAMP_RESET[23:0];
    end else if (wrDone && paddr == OFS_RAMP) begin
      rampFf <= pwdata[23:0];
    end
  end

  // Result of the last command write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      resultFf <= RES_OK;
    end else if (cmdWrite) begin
      resultFf <= nxt_result;
    end
  end

  // Internal source rate
  sls_tick_gen #(
    .INC(INT_SRC_HZ),
    .MOD(CLK_HZ)
  ) u_int_tick (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(intTick)
  );

  // On-board source rate, before the divider
  sls_tick_gen #(
    .INC(ONB_SRC_HZ),
    .MOD(CLK_HZ)
  ) u_onb_tick (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(onbTick)
  );

  // Divide by ratio plus one; compare is live so a new ratio acts at once
  assign preTick = onbTick && (preCntFf >= dividerXFf);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      preCntFf <= 8'h00;
    end else if (preTick) begin
      preCntFf <= 8'h00;
    end else if (onbTick) begin
      preCntFf <= preCntFf + 8'h01;
    end
  end

  // External clock edge; input is already synchronous
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      extPrevFf <= 1'b0;
    end else begin
      extPrevFf <= extClkIn;
    end
  end

  // Source selection; code 3 yields no ticks
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      srcTickFf <= 1'b0;
    end else begin
      case (srcSelFf)
        SRC_INT: srcTickFf <= intTick;
        SRC_ONB: srcTickFf <= preTick;
        SRC_EXT: srcTickFf <= extClkIn & ~extPrevFf;
        default: srcTickFf <= 1'b0;
      endcase
    end
  end

  // One sequencer per axis
  for (genvar i = 0; i < N_AXES; i++) begin : g_axis
    logic outerHit;
    logic innerHit;
    logic rampDue;
    logic running;

    assign busy[i] = (stateFf[i] != ST_IDLE);
    assign running = busy[i];
    assign outerHit = stepDir[i] ? cw_outer_limit[i] : ccw_outer_limit[i];
    assign innerHit = stepDir[i] ? cw_inner_limit[i] : ccw_inner_limit[i];
    assign rampDue = stepInt[i] && (rampCntFf[i] >= rampFf.len);

    sls_step_timer #(
      .DIV_W(DIV_W)
    ) u_timer (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .run(running),
      .srcTick(srcTickFf),
      .divisor(curDivFf[i]),
      .stepPulse(stepInt[i])
    );

    // Step output, suppressed once the axis has stopped
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        stepPulse[i] <= 1'b0;
      end else begin
        stepPulse[i] <= stepInt[i] & running;
      end
    end

    // Ramp interval counter, counts steps between divisor changes
    always_ff @(posedge ref_clk) begin
      if (!rst_n || !running) begin
        rampCntFf[i] <= 8'h00;
      end else if (rampDue) begin
        rampCntFf[i] <= 8'h00;
      end else if (stepInt[i]) begin
        rampCntFf[i] <= rampCntFf[i] + 8'h01;
      end
    end

    // Motion state; switches act the cycle they are seen
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        stateFf[i] <= ST_IDLE;
        curDivFf[i] <= DIV_MIN;
        stepDir[i] <= 1'b1;
        lastCodeFf[i] <= 3'h0;
        finInnerFf[i] <= 1'b0;
        finOuterFf[i] <= 1'b0;
      end else begin
        case (stateFf[i])
          ST_IDLE: begin
            if (startVec[i]) begin
              stepDir[i] <= dirReq;
              lastCodeFf[i] <= cmdReq.code[2:0];
              finInnerFf[i] <= 1'b0;
              finOuterFf[i] <= 1'b0;
              if (cmdReq.code == CMD_OUTER) begin
                stateFf[i] <= ST_CONST;
                curDivFf[i] <= cmdReq.div;
              end else begin
                stateFf[i] <= ST_ACCEL;
                curDivFf[i] <= rampFf.start;
              end
            end
          end
          ST_CONST: begin
            if (!motor_power_sense) begin
              stateFf[i] <= ST_IDLE;
            end else if (outerHit) begin
              stateFf[i] <= ST_IDLE;
              finOuterFf[i] <= 1'b1;
            end
          end
          ST_ACCEL: begin
            if (!motor_power_sense) begin
              stateFf[i] <= ST_IDLE;
            end else if (outerHit) begin
              stateFf[i] <= ST_IDLE;
              finOuterFf[i] <= 1'b1;
            end else if (innerHit) begin
              stateFf[i] <= ST_DECEL;
            end else if (rampDue && curDivFf[i] > rampFf.top) begin
              curDivFf[i] <= curDivFf[i] - 8'h01;
            end
          end
          ST_DECEL: begin
            if (!motor_power_sense) begin
              stateFf[i] <= ST_IDLE;
            end else if (outerHit) begin
              stateFf[i] <= ST_IDLE;
              finOuterFf[i] <= 1'b1;
            end else if (rampDue) begin
              if (curDivFf[i] < rampFf.start) begin
                curDivFf[i] <= curDivFf[i] + 8'h01;
              end else begin
                stateFf[i] <= ST_IDLE;
                finInnerFf[i] <= 1'b1;
              end
            end
          end
          default: stateFf[i] <= ST_IDLE;
        endcase
      end
    end
  end
endmodule : sls_seek_top
`default_nettype wire

// [testbench/sls_seek_chk.sv]
// Purpose: Port-level checks of the limit seek block
// Assumes: One clock domain, reset low
// Notes: Bound onto the top module below
`timescale 1ns/1ns
`default_nettype none
module sls_seek_chk #(
  parameter int N_AXES = 3
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic motor_power_sense,
  input wire logic [N_AXES-1:0] cw_outer_limit,
  input wire logic [N_AXES-1:0] ccw_outer_limit,
  input wire logic [N_AXES-1:0] stepPulse,
  input wire logic [N_AXES-1:0] stepDir
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Bus answer is one cycle and ends a real access phase
  property p_ready_once;
    pready |=> !pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready held");
  property p_ready_access;
    pready |-> psel && penable && $past(psel && penable);
  endproperty
  a_ready_access: assert property (p_ready_access) else $error("pready outside access");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr alone");
  // Unpowered motor gets no steps after a short pipeline
  property p_no_power;
    !motor_power_sense [*3] |-> stepPulse == '0;
  endproperty
  a_no_power: assert property (p_no_power) else $error("step without power");
  for (genvar g = 0; g < N_AXES; g++) begin : g_ax
    // Switch of the travel direction halts stepping
    property p_cw_stop;
      (cw_outer_limit[g] && stepDir[g]) [*3] |-> !stepPulse[g];
    endproperty
    a_cw_stop: assert property (p_cw_stop) else $error("step past cw switch");
    property p_ccw_stop;
      (ccw_outer_limit[g] && !stepDir[g]) [*3] |-> !stepPulse[g];
    endproperty
    a_ccw_stop: assert property (p_ccw_stop) else $error("step past ccw switch");
    // Direction only moves while the axis is quiet
    property p_dir_quiet;
      $changed(stepDir[g]) |=> !stepPulse[g] [*8];
    endproperty
    a_dir_quiet: assert property (p_dir_quiet) else $error("step right after turn");
    // Divisor of at least 20 keeps pulses far apart
    property p_step_gap;
      stepPulse[g] |=> !stepPulse[g] [*8];
    endproperty
    a_step_gap: assert property (p_step_gap) else $error("steps too close");
  end
endmodule : sls_seek_chk

bind sls_seek_top sls_seek_chk #(.N_AXES(N_AXES)) u_chk (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .pslverr(pslverr),
  .motor_power_sense(motor_power_sense),
  .cw_outer_limit(cw_outer_limit),
  .ccw_outer_limit(ccw_outer_limit),
  .stepPulse(stepPulse),
  .stepDir(stepDir)
);
`default_nettype wire

// [testbench/sls_motor_model.sv]
// Purpose: Motor drive with position and four switches per axis
// Assumes: Switches active high, level
// Notes: Position resets to zero
`timescale 1ns/1ns
`default_nettype none
module sls_motor_model #(
  parameter int NAX = 3,
  parameter int OUT = 40,
  parameter int INN = 10
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [NAX-1:0] stepPulse,
  input wire logic [NAX-1:0] stepDir,
  output logic [NAX-1:0] cwOut,
  output logic [NAX-1:0] ccwOut,
  output logic [NAX-1:0] cwIn,
  output logic [NAX-1:0] ccwIn,
  output var int pos [NAX]
);
  // One step moves the shaft one count
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < NAX; i++) begin
      if (!rst_n) pos[i] <= 0;
      else if (stepPulse[i]) pos[i] <= stepDir[i] ? pos[i] + 1 : pos[i] - 1;
    end
  end
  // Outer switches far enough out that a slow seek cannot overshoot
  for (genvar g = 0; g < NAX; g++) begin : g_sw
    assign cwOut[g] = pos[g] >= OUT;
    assign ccwOut[g] = pos[g] <= -OUT;
    assign cwIn[g] = pos[g] >= INN;
    assign ccwIn[g] = pos[g] <= -INN;
  end
endmodule : sls_motor_model
`default_nettype wire

// [testbench/stepper_limit_seek_bench.sv]
// Purpose: Self-checking bench for the limit seek block
// Assumes: Ext source rises every second cycle
// Notes: Random axis, divisor and step size
`timescale 1ns/1ns
`default_nettype none
module stepper_limit_seek_bench
  import sls_pkg::*;
;
  localparam int OUT = 40;
  localparam int INN = 10;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic extClkIn = 1'b0;
  logic motor_power_sense = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [2:0] cwOut, ccwOut, cwIn, ccwIn, stepPulse, stepDir;
  int pos [3];
  int n_fail = 0;
  int cmp_count = 0;
  // Clock and ext source
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) extClkIn <= ~extClkIn;
  sls_seek_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .extClkIn(extClkIn), .motor_power_sense(motor_power_sense),
    .cw_outer_limit(cwOut), .ccw_outer_limit(ccwOut), .cw_inner_limit(cwIn),
    .ccw_inner_limit(ccwIn), .stepPulse(stepPulse), .stepDir(stepDir));
  sls_motor_model #(.OUT(OUT), .INN(INN)) u_motor (.ref_clk(ref_clk), .rst_n(rst_n),
    .stepPulse(stepPulse), .stepDir(stepDir), .cwOut(cwOut), .ccwOut(ccwOut),
    .cwIn(cwIn), .ccwIn(ccwIn), .pos(pos));
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic tmo();
    n_fail++;
    $display("BAD %0t wait ran out", $time);
    print_verdict();
  endtask : tmo
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Expected cycles between steps
  function automatic int gapExp(input logic [1:0] src, input int dv, input int x);
    if (src == SRC_EXT) return dv * 2;
    if (src == SRC_INT) return int'((longint'(dv) * CLK_HZ) / INT_SRC_HZ);
    return int'((longint'(dv) * (x + 1) * CLK_HZ) / ONB_SRC_HZ);
  endfunction : gapExp
  // Onboard source has one cycle of jitter per tick
  function automatic logic near(input int g, input int e);
    return g >= e - 2 && g <= e + 2;
  endfunction : near
  // Held until pready, released after, one idle edge so no double drive
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) tmo();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd
  task automatic cmd(input logic [7:0] code, input logic [3:0] ax, input logic [7:0] dv,
                     output logic [3:0] res);
    logic [31:0] r;
    wr(OFS_CMD, {8'h00, dv, 4'h0, ax, code});
    rd(OFS_RESULT, r);
    res = r[3:0];
  endtask : cmd
  task automatic waitIdle(input int a);
    logic [31:0] r;
    int n;
    n = 0;
    do begin
      rd(OFS_STAT0 + 8'(4 * a), r);
      n++;
    end while (r[STAT_BUSY_BIT] !== 1'b0 && n < 3000);
    if (n >= 3000) tmo();
  endtask : waitIdle
  // Cycles from one step to the next
  task automatic measure(input int a, output int gap);
    int n;
    n = 0;
    while (stepPulse[a] !== 1'b1 && n < 6000) begin
      @(posedge ref_clk);
      n++;
    end
    gap = 0;
    do begin
      @(posedge ref_clk);
      gap++;
    end while (stepPulse[a] !== 1'b1 && gap < 6000);
    if (n >= 6000 || gap >= 6000) tmo();
  endtask : measure
  // Main sequence
  initial begin
    logic [31:0] r;
    logic e;
    logic [3:0] res;
    int ax, dv, gap;
    void'($urandom(32'h20C0105F));
    repeat (2) @(posedge ref_clk);
    chk({pready, pslverr, stepDir, stepPulse}, 32'h38);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(OFS_RAMP, r); chk(r, RAMP_RESET);
    rd(OFS_CLKCFG, r); chk(r, CLKCFG_RESET);
    apb(1'b0, 8'h40, 32'h0, r, e); chk(e, 1'b1);
    cmd(8'h10, 4'h0, 8'h14, res); chk(res, RES_BADCMD);
    cmd(CMD_OUTER, 4'h3, 8'h14, res); chk(res, RES_BADAXIS);
    cmd(CMD_OUTER, 4'h0, 8'h13, res); chk(res, RES_BADDIV);
    // Short ramp keeps the trapezoid run brief
    wr(OFS_CLKCFG, {30'h0, SRC_EXT});
    wr(OFS_RAMP, 32'h0000_141E);
    ax = $urandom_range(1, 0);
    dv = $urandom_range(25, 20);
    wr(OFS_STEPS, $urandom & 32'h00FF_FFFF);
    cmd(CMD_OUTER, 4'(ax), 8'(dv), res); chk(res, RES_OK);
    measure(ax, gap); chk(gap, gapExp(SRC_EXT, dv, 0));
    waitIdle(ax); chk(pos[ax], OUT);
    rd(OFS_STAT0 + 8'(4 * ax), r); chk(r[5:3], 3'b010);
    rd(OFS_RAMP, r); chk(r, 32'h0000_141E);
    wr(OFS_STEPS, 32'h0100_0000 | $urandom_range(999, 1));
    cmd(CMD_OUTER, 4'(ax), 8'(dv), res); chk(res, RES_OK);
    chk(stepDir[ax], 1'b0);
    waitIdle(ax); chk(pos[ax], -OUT);
    // Trapezoid toward the inner switch, divisor field ignored
    wr(OFS_STEPS, 32'h0000_0001);
    cmd(CMD_INNER, 4'(ax), 8'h00, res); chk(res, RES_OK);
    measure(ax, gap); chk(gap >= 40 && gap <= 60, 1'b1);
    waitIdle(ax); chk(pos[ax] > INN && pos[ax] <= INN + 15, 1'b1);
    rd(OFS_STAT0 + 8'(4 * ax), r); chk(r[4:3], 2'b01);
    // Onboard source, divider changed in motion, then power loss
    wr(OFS_CLKCFG, {30'h0, SRC_ONB});
    cmd(CMD_OUTER, 4'h2, 8'h14, res); chk(res, RES_OK);
    measure(2, gap); chk(near(gap, gapExp(SRC_ONB, 20, 0)), 1'b1);
    cmd(CMD_OUTER, 4'h2, 8'h14, res); chk(res, RES_BUSY);
    wr(OFS_CLKCFG, 32'h0000_0101);
    measure(2, gap); chk(near(gap, gapExp(SRC_ONB, 20, 1)), 1'b1);
    motor_power_sense <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd(OFS_STAT2, r); chk({r[STAT_BUSY_BIT], r[5:3]}, 4'b0100);
    cmd(CMD_OUTER, 4'h0, 8'h14, res); chk(res, RES_POWER);
    motor_power_sense <= 1'b1;
    // Codes up to CMD_MAX other than the two seeks are taken with no motion
    cmd(8'h03, 4'h2, 8'h14, res); chk(res, RES_OK);
    rd(OFS_STAT2, r); chk(r[STAT_BUSY_BIT], 1'b0);
    // Internal source runs free, so the first step lands 19 to 20 ticks in
    wr(OFS_CLKCFG, {30'h0, SRC_INT});
    cmd(CMD_OUTER, 4'h2, 8'h14, res); chk(res, RES_OK);
    gap = 0;
    while (stepPulse[2] !== 1'b1 && gap < 45000) begin
      @(posedge ref_clk);
      gap++;
    end
    if (gap >= 45000) tmo();
    chk(gap >= gapExp(SRC_INT, 19, 0) - 8 && gap <= gapExp(SRC_INT, 20, 0) + 8, 1'b1);
    print_verdict();
  end
endmodule : stepper_limit_seek_bench
`default_nettype wire
